// ### rtl/ipr_expand.sv
// extends instruction register selects from the latched prefix index
`timescale 1ns/100ps
`default_nettype none
module ipr_expand
  import ipr_pkg::*;
#(
  parameter int unsigned SRC_LO_W = IPR_SRC_LO_W,
  parameter int unsigned DST_LO_W = IPR_DST_LO_W
) (
  // prefix side
  input wire logic [ipr_pkg::IPR_IDX_W-1:0] idx_i,
  // instruction side
  input wire logic [SRC_LO_W-1:0] src_lo_i,
  input wire logic [DST_LO_W-1:0] dst_lo_i,
  output logic [SRC_LO_W:0] src_sel_o,
  output logic [DST_LO_W+1:0] dst_sel_o
);
  initial begin
    if (SRC_LO_W == 0 || DST_LO_W == 0) begin
      $error("ipr_expand: field widths must be nonzero");
    end
  end
  wire logic src_hi = idx_i[IPR_IDX_SRC_BIT];
  wire logic [1:0] dst_hi = idx_i[IPR_IDX_DST_LO +: 2];
  assign src_sel_o = {src_hi, src_lo_i};
  assign dst_sel_o = {dst_hi, dst_lo_i};
endmodule
`default_nettype wire

// ### rtl/ipr_pkg.sv
// constants and types for the instruction prefix register
// Overview of operation
// - every reset clears prefix to zero
// - low byte feeds next instruction's high byte
// - value lasts one cycle, then zero
// - only low eight bits prefix the instruction
// - all indexes share one 16-bit register
// - write index extends source and destination selects
// - index zero limits source 0-f, destination 0-7
package ipr_pkg;
  localparam int unsigned IPR_DATA_W = 16;
  localparam int unsigned IPR_IDX_W = 3;
  localparam int unsigned IPR_SRC_LO_W = 4;
  localparam int unsigned IPR_DST_LO_W = 3;
  localparam int unsigned IPR_BYTE_W = 8;
  localparam logic [15:0] IPR_RESET_VAL = 16'h0000;
  localparam logic [2:0] IPR_IDX_ZERO = 3'h0;
  localparam int unsigned IPR_IDX_SRC_BIT = 0;
  localparam int unsigned IPR_IDX_DST_LO = 1;
  // avalon word map: one word per index, module base at register index 0b
  localparam int unsigned IPR_MOD_INDEX = 'hb;
  localparam logic [3:0] IPR_ADDR_PFX0 = 4'h0;
  localparam logic [3:0] IPR_ADDR_LAST = 4'h7;
  localparam logic [3:0] IPR_ADDR_STATUS = 4'h8;
  localparam logic [31:0] IPR_UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {IPR_IDLE, IPR_ARMED} ipr_state_t;
endpackage

// ### rtl/ipr_top.sv
// instruction prefix register with move-datapath, decode and avalon ports
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module ipr_top
  import ipr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register-move datapath write/read of the prefix module
  input wire logic mv_wr_i,
  input wire logic [ipr_pkg::IPR_IDX_W-1:0] mv_idx_i,
  input wire logic [ipr_pkg::IPR_DATA_W-1:0] mv_wdata_i,
  output logic [ipr_pkg::IPR_DATA_W-1:0] mv_rdata_o,
  // next-instruction decode
  input wire logic [ipr_pkg::IPR_SRC_LO_W-1:0] dec_src_lo_i,
  input wire logic [ipr_pkg::IPR_DST_LO_W-1:0] dec_dst_lo_i,
  output logic [ipr_pkg::IPR_SRC_LO_W:0] dec_src_sel_o,
  output logic [ipr_pkg::IPR_DST_LO_W+1:0] dec_dst_sel_o,
  output logic [ipr_pkg::IPR_BYTE_W-1:0] dec_imm_hi_o,
  output logic dec_prefixed_o,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import ipr_pkg::*;

  logic [IPR_DATA_W-1:0] pfx_q, pfx_d;
  logic [IPR_IDX_W-1:0] idx_q, idx_d;
  ipr_state_t state_q, state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [IPR_DATA_W-1:0] last_q;

  // avalon decode: waitrequest high until one-cycle ack
  wire logic av_req = avs_read | avs_write;
  wire logic av_pfx_hit = avs_address <= IPR_ADDR_LAST;
  wire logic av_status_hit = avs_address == IPR_ADDR_STATUS;
  wire logic av_wr = avs_write & ack_q & av_pfx_hit;
  wire logic [IPR_DATA_W-1:0] av_wdata = {
    avs_byteenable[1] ? avs_writedata[15:8] : pfx_q[15:8],
    avs_byteenable[0] ? avs_writedata[7:0] : pfx_q[7:0]};
  assign avs_waitrequest = av_req & ~ack_q;
  assign avs_readdata = rdata_q;

  // datapath move wins over a bus write in the same cycle
  wire logic any_wr = mv_wr_i | av_wr;
  wire logic [IPR_DATA_W-1:0] wr_val = mv_wr_i ? mv_wdata_i : av_wdata;
  wire logic [IPR_IDX_W-1:0] wr_idx = mv_wr_i ? mv_idx_i : avs_address[IPR_IDX_W-1:0];

  // one-cycle life: a write arms, the next cycle reverts to zero
  always_comb begin
    state_d = any_wr ? IPR_ARMED : IPR_IDLE;
    pfx_d = any_wr ? wr_val : IPR_RESET_VAL;
    idx_d = any_wr ? wr_idx : IPR_IDX_ZERO;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pfx_q <= IPR_RESET_VAL;
      idx_q <= IPR_IDX_ZERO;
      state_q <= IPR_IDLE;
    end else begin
      pfx_q <= pfx_d;
      idx_q <= idx_d;
      state_q <= state_d;
    end
  end

  // last written value kept for software inspection only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_q <= IPR_RESET_VAL;
    end else if (any_wr) begin
      last_q <= wr_val;
    end
  end

  wire logic [31:0] av_rd_mux = av_pfx_hit ? {16'h0000, pfx_q} :
    av_status_hit ? {12'h000, 1'b0, idx_q, last_q} : IPR_UNMAPPED_RD;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= IPR_UNMAPPED_RD;
    end else begin
      ack_q <= av_req & ~ack_q;
      rdata_q <= (avs_read & ~ack_q) ? av_rd_mux : rdata_q;
    end
  end

  // every index reads the same storage
  assign mv_rdata_o = pfx_q;

  // decode view: only the low byte prefixes
  logic armed;
  always_comb begin
    case (state_q)
      IPR_ARMED: armed = 1'b1;
      IPR_IDLE: armed = 1'b0;
      default: armed = 1'b0;
    endcase
  end
  assign dec_imm_hi_o = pfx_q[IPR_BYTE_W-1:0];
  assign dec_prefixed_o = armed;

  ipr_expand #(
    .SRC_LO_W(IPR_SRC_LO_W),
    .DST_LO_W(IPR_DST_LO_W)
  ) u_expand (
    .idx_i(idx_q),
    .src_lo_i(dec_src_lo_i),
    .dst_lo_i(dec_dst_lo_i),
    .src_sel_o(dec_src_sel_o),
    .dst_sel_o(dec_dst_sel_o)
  );

  // checks
  sequence s_write;
    any_wr;
  endsequence
  sequence s_armed;
    armed && dec_prefixed_o;
  endsequence
  sequence s_cleared;
    pfx_q == IPR_RESET_VAL && !armed && idx_q == IPR_IDX_ZERO;
  endsequence

  // async reset: cleared state must show on every sampled reset cycle
  a_reset_clear: assert property (@(posedge clk_sys_i) sys_rst_i |-> s_cleared)
    else $error("prefix not cleared by reset");
  a_imm_byte: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    any_wr |=> dec_imm_hi_o == $past(wr_val[7:0]))
    else $error("next instruction lacks prefix byte");
  a_one_cycle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_write |=> s_armed)
    else $error("prefix not armed after write");
  // a back-to-back write legitimately refills, so only a quiet cycle must clear
  a_revert_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_write ##1 !any_wr |=> s_cleared)
    else $error("prefix did not revert after one cycle");
  a_upper_unused: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (any_wr && wr_val[15:8] != 8'h00) |=> dec_imm_hi_o == $past(wr_val[7:0]))
    else $error("upper prefix byte leaked");
  a_shared_store: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mv_wr_i |=> mv_rdata_o == $past(mv_wdata_i))
    else $error("index did not reach shared storage");
  a_index_select: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mv_wr_i |=> dec_src_sel_o[4] == $past(mv_idx_i[0]) && dec_dst_sel_o[4:3] == $past(mv_idx_i[2:1]))
    else $error("write index not applied to selects");
  a_idx0_range: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mv_wr_i && mv_idx_i == IPR_IDX_ZERO) |=> dec_src_sel_o <= 5'h0f && dec_dst_sel_o <= 5'h07)
    else $error("index zero range exceeded");
  a_no_prefix: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !any_wr |=> dec_imm_hi_o == 8'h00 && idx_q == IPR_IDX_ZERO && !dec_prefixed_o)
    else $error("unprefixed instruction not decoded as index zero");
endmodule
`default_nettype wire

// ### testbench/ipr_mv_model.sv
// move-datapath model issuing prefix writes
`timescale 1ns/100ps
`default_nettype none
module ipr_mv_model (
  input wire logic clk_sys_i,
  input wire logic req_i,
  input wire logic [2:0] idx_i,
  input wire logic [15:0] data_i,
  output logic mv_wr_o = 1'b0,
  output logic [2:0] mv_idx_o = 3'h0,
  output logic [15:0] mv_wdata_o = 16'h0
);
  // one-cycle strobe per request; idle data keeps changing
  always @(posedge clk_sys_i) begin
    mv_wr_o <= req_i;
    mv_idx_o <= req_i ? idx_i : ~mv_idx_o;
    mv_wdata_o <= req_i ? data_i : ~mv_wdata_o;
  end
endmodule
`default_nettype wire

// ### testbench/tb_instruction_prefix_register.sv
// self-checking bench for the prefix register
`timescale 1ns/100ps
`default_nettype none
module tb_instruction_prefix_register;
  import ipr_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1, req = 0, mv_wr, avs_read = 0, avs_write = 0, instruction_prefix, avs_waitrequest;
  logic [2:0] idx = 0, mv_idx, dst_lo = 0;
  logic [15:0] data = 0, mv_wdata, mv_rdata;
  logic [3:0] src_lo = 0, avs_address = 0;
  logic [4:0] src_sel, dst_sel;
  logic [7:0] imm;
  logic [31:0] avs_writedata = 0, avs_readdata, d, e;
  logic [31:0] pq[$], rq[$];
  int n_fail = 0, check_count = 0, seed = 32'hbc1543f7;
  ipr_top u_dut (.clk_sys_i, .sys_rst_i, .mv_wr_i(mv_wr), .mv_idx_i(mv_idx), .mv_wdata_i(mv_wdata),
    .mv_rdata_o(mv_rdata), .dec_src_lo_i(src_lo), .dec_dst_lo_i(dst_lo), .dec_src_sel_o(src_sel),
    .dec_dst_sel_o(dst_sel), .dec_imm_hi_o(imm), .dec_prefixed_o(instruction_prefix), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest);
  ipr_mv_model u_mv (.clk_sys_i, .req_i(req), .idx_i(idx), .data_i(data), .mv_wr_o(mv_wr),
    .mv_idx_o(mv_idx), .mv_wdata_o(mv_wdata));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) n_fail++;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    src_lo <= 4'($random(seed));
    dst_lo <= 3'($random(seed));
  end
  // previous cycle's settled outputs against queued writes
  always @(posedge clk_sys_i) if (!sys_rst_i) begin
    if (instruction_prefix === 1'b1) begin
      e = pq.pop_front();
      chk(imm, e[7:0]);
      chk(mv_rdata, e[15:0]);
      chk(src_sel, {e[16], src_lo});
      chk(dst_sel, {e[18:17], dst_lo});
    end else begin
      chk({imm, mv_rdata}, 0);
      chk({src_sel[4], dst_sel[4:3]}, 0);
    end
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, rq.pop_front());
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    chk({imm, mv_rdata, instruction_prefix}, 0);
    sys_rst_i <= 0;
    // eight back-to-back writes, then spaced ones
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys_i);
      d = $random(seed);
      req <= (i < 8 || i % 3 == 0);
      idx <= i[2:0];
      data <= d[15:0];
      if (i < 8 || i % 3 == 0) pq.push_back({i[2:0], d[15:0]});
    end
    repeat (4) @(posedge clk_sys_i);
    d = $random(seed);
    pq.push_back({3'h3, d[15:0]});
    bus(1, 4'h3, d);
    bus(1, 4'h9, d);
    rq.push_back(0);
    bus(0, 4'h5, 0);
    rq.push_back(0);
    bus(0, 4'h9, 0);
    rq.push_back({16'h0000, d[15:0]});
    bus(0, 4'h8, 0);
    repeat (4) @(posedge clk_sys_i);
    chk(pq.size() + rq.size(), 0);
    print_verdict();
  end
  initial begin
    #20us;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
